// File: mcs_pkg.sv
/*
  Constants, types and helper functions shared by the motor controller
  mode, configuration and status indication logic.
  Assumes a single 100 MHz system clock; all times are given in
  milliseconds and turned into cycle counts with ms_to_cycles.
*/
// Notes on behaviour
// [R1] power-up: blink all three indicators briefly
// [R2] analog mode: activity indicator steadily lit
// [R3] rc mode: lit, brief blink per pulse
// [R4] serial modes: lit, brief blink per receive
// [R5] motor indicator lit while any channel driven
// [R6] over-current: fault indicator steadily lit
// [R7] over-temperature: fault indicator toggles every 75 ms
// [R8] main battery low: half-second blinking
// [R9] main battery high: 1 s on, 0.3 s off
// [R10] logic battery low: 0.5 s on, 0.5 s off
// [R11] quad fail at start: fault/motor indicators alternate
// [R12] three cutoff switches select the threshold
// [R13] below cutoff: stop both motors, report fault
// [R14] control inputs one/two carry commands
// [R15] flip input only in rc and analog
// [R16] four modes; no encoders in rc/analog
// [R17] simple serial never transmits
// [R18] simple serial slave select option
// [R19] packet serial address from switches, eight values
// [R20] encoders need packet serial, which transmits
// [R21] counter direction follows leading phase
// [R22] ten switches, marked position reads on
// [R23] host drives input two high to select
package mcs_pkg;

  localparam int CLOCK_KHZ = 100000;
  localparam int TIMER_W   = 27;

  localparam int SELF_TEST_ON_MS  = 100;
  localparam int SELF_TEST_OFF_MS = 100;
  localparam int SELF_TEST_BLINKS = 3;
  localparam int ACTIVITY_DARK_MS = 50;
  localparam int FAST_TOGGLE_MS   = 75;
  localparam int HALF_SEC_MS      = 500;
  localparam int FLICKER_ON_MS    = 1000;
  localparam int FLICKER_OFF_MS   = 300;

  localparam int SWITCH_COUNT  = 10;
  localparam int SW_MODE_A     = 0;
  localparam int SW_MODE_B     = 1;
  localparam int SW_MODE_C     = 2;
  localparam int SW_ADDR_LO    = 3;
  localparam int SW_CUTOFF_LO  = 7;
  localparam int ADDR_W        = 3;
  localparam int MV_W          = 16;

  localparam logic [2:0]  CUT_NONE        = 3'h0;
  localparam logic [2:0]  CUT_LEAD_ACID   = 3'h1;
  localparam logic [15:0] CUTOFF_STEP_MV  = 16'hbb8;

  typedef enum logic [1:0]
  {
    MODE_RC            = 2'b00,
    MODE_ANALOG        = 2'b01,
    MODE_SIMPLE_SERIAL = 2'b10,
    MODE_PACKET_SERIAL = 2'b11
  } mcs_mode_t;

  typedef enum logic [2:0]
  {
    ERR_NONE    = 3'b000,
    ERR_SOLID   = 3'b001,
    ERR_FAST    = 3'b010,
    ERR_HALF    = 3'b011,
    ERR_FLICKER = 3'b100,
    ERR_STEADY  = 3'b101,
    ERR_QUAD    = 3'b110
  } mcs_err_t;

  function automatic int ms_to_cycles(input int ms);
    int cyc;
    cyc = ms * CLOCK_KHZ;
    return (cyc < 1) ? 1 : cyc;
  endfunction

endpackage

// File: mcs_event_stretch.sv
/*
  Stretches a one-cycle event into a pulse of fixed length; a new event
  restarts the pulse. Used to darken the activity indicator briefly.
  Assumes events are synchronous to the clock.
*/
`timescale 1ns/1ps
module mcs_event_stretch
#(
  parameter int unsigned LENGTH_CYC = 5000000
)
(
  input  wire logic                       i_clock,
  input  wire logic                       i_reset_n,
  input  wire logic                       i_event,
  output logic                            o_active
);
  import mcs_pkg::*;

  logic [TIMER_W-1:0] remain_reg;

  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
      remain_reg <= '0;
    else if (i_event)
      remain_reg <= TIMER_W'(LENGTH_CYC);
    else if (remain_reg != '0)
      remain_reg <= remain_reg - 1'b1;
  end

  assign o_active = (remain_reg != '0);

endmodule

// File: mcs_quad_counter.sv
/*
  Quadrature position counter for one encoder. Counts up when phase A
  leads phase B and down when it lags.
  Assumes the phases are already synchronous and clean; a step that
  changes both phases at once is treated as noise and skipped.
*/
`timescale 1ns/1ps
module mcs_quad_counter
#(
  parameter int unsigned COUNT_W = 32
)
(
  input  wire logic               i_clock,
  input  wire logic               i_reset_n,
  input  wire logic               i_enable,
  input  wire logic               i_phase_a,
  input  wire logic               i_phase_b,
  output logic [COUNT_W-1:0]      o_count
);
  import mcs_pkg::*;

  logic prev_a_reg;
  logic prev_b_reg;
  logic one_step;
  logic count_up;

  assign one_step = (prev_a_reg ^ i_phase_a) ^ (prev_b_reg ^ i_phase_b);
  // forward sequence 00,10,11,01 always has prev_a equal to new b
  assign count_up = ~(prev_a_reg ^ i_phase_b); // R21

  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      prev_a_reg <= 1'b0;
      prev_b_reg <= 1'b0;
    end
    else
    begin
      prev_a_reg <= i_phase_a;
      prev_b_reg <= i_phase_b;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_count <= '0;
    else if (i_enable && one_step)
      o_count <= count_up ? o_count + 1'b1 : o_count - 1'b1; // R21
  end

endmodule

// File: mcs_mode_status.sv
/*
  Mode selection, configuration decode and indicator logic of a
  dual-channel brushed motor controller: decodes nine of the ten configuration
  switches, gates the control inputs, encoders and serial transmitter by
  mode, applies the low-voltage cutoff and drives the activity, motor
  and fault indicators.
  Assumes all inputs are synchronous to i_clock, and that motor drive,
  fault detection and serial reception live outside and report here.
*/
`timescale 1ns/1ps
module mcs_mode_status
  import mcs_pkg::*;
#(
  parameter int unsigned SELF_TEST_ON_CYC  = mcs_pkg::ms_to_cycles(mcs_pkg::SELF_TEST_ON_MS),
  parameter int unsigned SELF_TEST_OFF_CYC = mcs_pkg::ms_to_cycles(mcs_pkg::SELF_TEST_OFF_MS),
  parameter int unsigned ACTIVITY_DARK_CYC = mcs_pkg::ms_to_cycles(mcs_pkg::ACTIVITY_DARK_MS),
  parameter int unsigned FAST_TOGGLE_CYC   = mcs_pkg::ms_to_cycles(mcs_pkg::FAST_TOGGLE_MS),
  parameter int unsigned HALF_SEC_CYC      = mcs_pkg::ms_to_cycles(mcs_pkg::HALF_SEC_MS),
  parameter int unsigned FLICKER_ON_CYC    = mcs_pkg::ms_to_cycles(mcs_pkg::FLICKER_ON_MS),
  parameter int unsigned FLICKER_OFF_CYC   = mcs_pkg::ms_to_cycles(mcs_pkg::FLICKER_OFF_MS),
  parameter logic [15:0] LEAD_ACID_CUTOFF_MV = 16'h1770,
  parameter int unsigned ENC_COUNT_W       = 32
)
(
  input  wire logic                              i_clock,
  input  wire logic                              i_resetn,
  input  wire logic [mcs_pkg::SWITCH_COUNT-1:0]  i_config_switch,
  input  wire logic                              i_control_input_one,
  input  wire logic                              i_control_input_two,
  input  wire logic                              i_flip_over_input,
  input  wire logic                              i_rc_pulse_seen,
  input  wire logic                              i_serial_rx_seen,
  input  wire logic [1:0]                        i_motor_driven,
  input  wire logic                              i_over_current,
  input  wire logic                              i_over_temp,
  input  wire logic                              i_main_batt_high,
  input  wire logic                              i_logic_batt_low,
  input  wire logic                              i_quad_fail,
  input  wire logic [mcs_pkg::MV_W-1:0]          i_main_batt_mv,
  input  wire logic [1:0]                        i_enc_phase_a,
  input  wire logic [1:0]                        i_enc_phase_b,
  output mcs_pkg::mcs_mode_t                     o_mode,
  output logic                                   o_command_one,
  output logic                                   o_command_two,
  output logic                                   o_command_enable,
  output logic                                   o_flip_over,
  output logic                                   o_serial_tx_enable,
  output logic [mcs_pkg::ADDR_W-1:0]             o_bus_address,
  output logic                                   o_encoder_enable,
  output logic [ENC_COUNT_W-1:0]                 o_enc_count_one,
  output logic [ENC_COUNT_W-1:0]                 o_enc_count_two,
  output logic                                   o_motor_drive_enable,
  output logic                                   o_low_batt_fault,
  output logic                                   o_activity_indicator,
  output logic                                   o_motor_active_indicator,
  output logic                                   o_fault_indicator
);

  typedef enum logic [1:0]
  {
    ST_TEST_ON  = 2'b00,
    ST_TEST_OFF = 2'b01,
    ST_RUN      = 2'b10
  } mcs_start_t;

  logic               rst_sync1_reg;
  logic               rst_n;
  mcs_start_t         start_reg;
  mcs_start_t         start_next;
  logic [TIMER_W-1:0] start_cnt_reg;
  logic [1:0]         blinks_reg;
  logic               start_len_done;
  logic               running;
  logic               quad_fail_reg;
  mcs_mode_t          mode_next;
  logic               slave_select_on;
  logic [2:0]         cutoff_code;
  logic [MV_W-1:0]    cutoff_mv;
  logic               low_batt_next;
  logic               activity_event;
  logic               activity_dark;
  mcs_err_t           err_next;
  mcs_err_t           err_reg;
  logic               err_phase_reg;
  logic [TIMER_W-1:0] err_cnt_reg;
  logic [TIMER_W-1:0] err_len;
  logic               activity_next;
  logic               motor_led_next;
  logic               fault_led_next;

  // reset is released through two flops; everything else uses rst_n
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rst_sync1_reg <= 1'b0;
      rst_n         <= 1'b0;
    end
    else
    begin
      rst_sync1_reg <= 1'b1;
      rst_n         <= rst_sync1_reg;
    end
  end

  // a switch in its marked position reads as 1
  always_comb
  begin
    if (i_config_switch[SW_MODE_C]) // R22
      mode_next = MODE_PACKET_SERIAL;
    else if (i_config_switch[SW_MODE_B])
      mode_next = MODE_SIMPLE_SERIAL;
    else if (i_config_switch[SW_MODE_A])
      mode_next = MODE_RC;
    else
      mode_next = MODE_ANALOG; // R16
  end

  // in simple serial the first mode switch is reused as slave select
  assign slave_select_on = (mode_next == MODE_SIMPLE_SERIAL) && i_config_switch[SW_MODE_A]; // R18

  assign cutoff_code = i_config_switch[SW_CUTOFF_LO +: 3]; // R12

  always_comb
  begin
    case (cutoff_code)
      CUT_NONE:      cutoff_mv = '0;
      CUT_LEAD_ACID: cutoff_mv = LEAD_ACID_CUTOFF_MV;
      default:       cutoff_mv = MV_W'(cutoff_code * CUTOFF_STEP_MV); // R12
    endcase
  end

  assign low_batt_next = (cutoff_code != CUT_NONE) && (i_main_batt_mv < cutoff_mv); // R13

  always_ff @(posedge i_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_mode        <= MODE_ANALOG;
      o_bus_address <= '0;
    end
    else
    begin
      o_mode        <= mode_next; // R16
      o_bus_address <= i_config_switch[SW_ADDR_LO +: ADDR_W]; // R19
    end
  end

  always_ff @(posedge i_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_command_one    <= 1'b0;
      o_command_two    <= 1'b0;
      o_command_enable <= 1'b0;
      o_flip_over      <= 1'b0;
    end
    else
    begin
      o_command_one    <= i_control_input_one; // R14
      o_command_two    <= i_control_input_two; // R14
      // with slave select the host parks input two low to mute this unit
      o_command_enable <= !slave_select_on || i_control_input_two; // R18 R23
      o_flip_over      <= i_flip_over_input && ((mode_next == MODE_RC) || (mode_next == MODE_ANALOG)); // R15
    end
  end

  always_ff @(posedge i_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_serial_tx_enable <= 1'b0;
      o_encoder_enable   <= 1'b0;
    end
    else
    begin
      // only packet serial talks back; simple serial stays receive-only
      o_serial_tx_enable <= (mode_next == MODE_PACKET_SERIAL); // R17 R20
      o_encoder_enable   <= (mode_next == MODE_PACKET_SERIAL); // R16 R20
    end
  end

  always_ff @(posedge i_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_low_batt_fault     <= 1'b0;
      o_motor_drive_enable <= 1'b0;
    end
    else
    begin
      o_low_batt_fault     <= low_batt_next; // R13
      // motors stay off through the lamp test so the start is quiet
      o_motor_drive_enable <= running && !low_batt_next; // R13
    end
  end

  mcs_quad_counter
  #(
    .COUNT_W (ENC_COUNT_W)
  )
  u_enc_one
  (
    .i_clock   (i_clock),
    .i_reset_n (rst_n),
    .i_enable  (o_encoder_enable),
    .i_phase_a (i_enc_phase_a[0]),
    .i_phase_b (i_enc_phase_b[0]),
    .o_count   (o_enc_count_one)
  );

  mcs_quad_counter
  #(
    .COUNT_W (ENC_COUNT_W)
  )
  u_enc_two
  (
    .i_clock   (i_clock),
    .i_reset_n (rst_n),
    .i_enable  (o_encoder_enable),
    .i_phase_a (i_enc_phase_a[1]),
    .i_phase_b (i_enc_phase_b[1]),
    .o_count   (o_enc_count_two)
  );

  // power-up lamp test
  assign running = (start_reg == ST_RUN);
  assign start_len_done = (start_reg == ST_TEST_ON)
                          ? (start_cnt_reg >= TIMER_W'(SELF_TEST_ON_CYC - 1))
                          : (start_cnt_reg >= TIMER_W'(SELF_TEST_OFF_CYC - 1));

  always_comb
  begin
    case (start_reg)
      ST_TEST_ON:  start_next = start_len_done ? ST_TEST_OFF : ST_TEST_ON;
      ST_TEST_OFF:
      begin
        if (!start_len_done)
          start_next = ST_TEST_OFF;
        else if (blinks_reg == 2'(SELF_TEST_BLINKS - 1))
          start_next = ST_RUN;
        else
          start_next = ST_TEST_ON; // R1
      end
      ST_RUN:      start_next = ST_RUN;
      default:     start_next = ST_RUN;
    endcase
  end

  always_ff @(posedge i_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      start_reg     <= ST_TEST_ON;
      start_cnt_reg <= '0;
      blinks_reg    <= '0;
    end
    else
    begin
      start_reg <= start_next;
      if (start_next != start_reg)
        start_cnt_reg <= '0;
      else if (!running)
        start_cnt_reg <= start_cnt_reg + 1'b1;
      if ((start_reg == ST_TEST_OFF) && (start_next == ST_TEST_ON))
        blinks_reg <= blinks_reg + 1'b1; // R1
    end
  end

  // decoder failure is only looked for while starting up, then held
  always_ff @(posedge i_clock or negedge rst_n)
  begin
    if (!rst_n)
      quad_fail_reg <= 1'b0;
    else if (!running && i_quad_fail && (mode_next == MODE_PACKET_SERIAL))
      quad_fail_reg <= 1'b1; // R11
  end

  // activity indicator darkens briefly on each pulse or received byte
  assign activity_event = ((mode_next == MODE_RC) && i_rc_pulse_seen) // R3
                       || (((mode_next == MODE_SIMPLE_SERIAL) || (mode_next == MODE_PACKET_SERIAL))
                           && i_serial_rx_seen); // R4

  mcs_event_stretch
  #(
    .LENGTH_CYC (ACTIVITY_DARK_CYC)
  )
  u_activity
  (
    .i_clock   (i_clock),
    .i_reset_n (rst_n),
    .i_event   (activity_event),
    .o_active  (activity_dark)
  );

  // fault priority: the most severe condition owns the indicator
  always_comb
  begin
    if (i_over_current)
      err_next = ERR_SOLID; // R6
    else if (i_over_temp)
      err_next = ERR_FAST; // R7
    else if (low_batt_next)
      err_next = ERR_HALF; // R8
    else if (i_main_batt_high)
      err_next = ERR_FLICKER; // R9
    else if (i_logic_batt_low)
      err_next = ERR_STEADY; // R10
    else if (quad_fail_reg)
      err_next = ERR_QUAD; // R11
    else
      err_next = ERR_NONE;
  end

  always_comb
  begin
    case (err_reg)
      ERR_FAST:    err_len = TIMER_W'(FAST_TOGGLE_CYC); // R7
      ERR_HALF:    err_len = TIMER_W'(HALF_SEC_CYC); // R8
      ERR_FLICKER: err_len = err_phase_reg ? TIMER_W'(FLICKER_ON_CYC) : TIMER_W'(FLICKER_OFF_CYC); // R9
      ERR_STEADY:  err_len = TIMER_W'(HALF_SEC_CYC); // R10
      ERR_QUAD:    err_len = TIMER_W'(HALF_SEC_CYC);
      default:     err_len = TIMER_W'(HALF_SEC_CYC);
    endcase
  end

  // a pattern change restarts at the lit phase so it is seen at once
  always_ff @(posedge i_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      err_reg       <= ERR_NONE;
      err_phase_reg <= 1'b1;
      err_cnt_reg   <= '0;
    end
    else
    begin
      err_reg <= err_next;
      if (err_next != err_reg)
      begin
        err_phase_reg <= 1'b1;
        err_cnt_reg   <= '0;
      end
      else if (err_cnt_reg >= err_len - 1'b1)
      begin
        err_phase_reg <= ~err_phase_reg;
        err_cnt_reg   <= '0;
      end
      else
        err_cnt_reg <= err_cnt_reg + 1'b1;
    end
  end

  always_comb
  begin
    activity_next  = 1'b1;
    motor_led_next = |i_motor_driven; // R5
    case (err_reg)
      ERR_NONE:  fault_led_next = 1'b0;
      ERR_SOLID: fault_led_next = 1'b1; // R6
      ERR_QUAD:
      begin
        fault_led_next = err_phase_reg; // R11
        motor_led_next = ~err_phase_reg; // R11
      end
      default:   fault_led_next = err_phase_reg;
    endcase
    if (o_mode == MODE_ANALOG)
      activity_next = 1'b1; // R2
    else
      activity_next = !activity_dark; // R3 R4
    if (!running)
    begin
      activity_next  = (start_reg == ST_TEST_ON); // R1
      motor_led_next = (start_reg == ST_TEST_ON); // R1
      fault_led_next = (start_reg == ST_TEST_ON); // R1
    end
  end

  always_ff @(posedge i_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_activity_indicator     <= 1'b0;
      o_motor_active_indicator <= 1'b0;
      o_fault_indicator        <= 1'b0;
    end
    else
    begin
      o_activity_indicator     <= activity_next;
      o_motor_active_indicator <= motor_led_next;
      o_fault_indicator        <= fault_led_next;
    end
  end

endmodule

// File: mcs_mode_status_monitor.sv
/*
  Concurrent checks on the ports of mcs_mode_status.
  Assumes one clock and the active-low asynchronous reset of the block.
*/
`timescale 1ns/1ps
module mcs_mode_status_monitor
  import mcs_pkg::*;
(
  input wire logic         i_clock,
  input wire logic         i_resetn,
  input wire logic [9:0]   i_config_switch,
  input wire logic         i_control_input_one,
  input wire logic         i_control_input_two,
  input wire logic [1:0]   i_motor_driven,
  input wire logic         i_over_current,
  input mcs_pkg::mcs_mode_t o_mode,
  input wire logic         o_command_one,
  input wire logic         o_command_enable,
  input wire logic         o_flip_over,
  input wire logic         o_serial_tx_enable,
  input wire logic [2:0]   o_bus_address,
  input wire logic         o_encoder_enable,
  input wire logic         o_motor_drive_enable,
  input wire logic         o_motor_active_indicator,
  input wire logic         o_fault_indicator
);
  logic [2:0] up_cnt;
  logic [2:0] run_cnt;
  logic       ready;
  logic       run;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  // outputs settle a few edges after release
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
      up_cnt <= 3'h0;
    else if (up_cnt != 3'h7)
      up_cnt <= up_cnt + 3'h1;
  end

  // indicator checks wait out the lamp test
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
      run_cnt <= 3'h0;
    else if (!o_motor_drive_enable)
      run_cnt <= 3'h0;
    else if (run_cnt != 3'h7)
      run_cnt <= run_cnt + 3'h1;
  end

  assign ready = (up_cnt >= 3'h4);
  assign run   = (run_cnt >= 3'h4) && o_motor_drive_enable;

  function automatic mcs_mode_t mode_of(input logic [2:0] s);
    return s[2] ? MODE_PACKET_SERIAL : (s[1] ? MODE_SIMPLE_SERIAL : (s[0] ? MODE_RC : MODE_ANALOG));
  endfunction

  sequence s_oc_seen;
    run && i_over_current ##2 run;
  endsequence

  property p_mode; ready |-> o_mode == mode_of($past(i_config_switch[2:0])); endproperty
  a_mode: assert property (p_mode) else $error("bad mode");
  property p_cmd; ready |-> o_command_one == $past(i_control_input_one); endproperty
  a_cmd: assert property (p_cmd) else $error("bad command");
  property p_flip; o_mode inside {MODE_SIMPLE_SERIAL, MODE_PACKET_SERIAL} |-> !o_flip_over; endproperty
  a_flip: assert property (p_flip) else $error("flip in serial");
  property p_tx; o_serial_tx_enable == (o_mode == MODE_PACKET_SERIAL); endproperty
  a_tx: assert property (p_tx) else $error("bad tx enable");
  property p_enc; o_encoder_enable |-> o_mode == MODE_PACKET_SERIAL; endproperty
  a_enc: assert property (p_enc) else $error("encoders outside packet");
  property p_addr; ready |-> o_bus_address == $past(i_config_switch[5:3]); endproperty
  a_addr: assert property (p_addr) else $error("bad address");
  property p_sel;
    ready |-> o_command_enable ==
      !$past(!i_config_switch[2] && i_config_switch[1] && i_config_switch[0] && !i_control_input_two);
  endproperty
  a_sel: assert property (p_sel) else $error("bad command enable");
  property p_led2;
    run && o_mode != MODE_PACKET_SERIAL |-> o_motor_active_indicator == |$past(i_motor_driven);
  endproperty
  a_led2: assert property (p_led2) else $error("bad motor indicator");
  property p_oc; s_oc_seen |-> o_fault_indicator; endproperty
  a_oc: assert property (p_oc) else $error("fault indicator dark");
endmodule

bind mcs_mode_status mcs_mode_status_monitor u_mon (.*);

// File: mcs_host_model.sv
/*
  Host model: drives the control pins, reports pulses and bytes
  as one-cycle events.
  Assumes requests change just after a rising edge.
*/
`timescale 1ns/1ps
module mcs_host_model
(
  input  wire logic i_clock,
  input  wire logic i_cmd_one,
  input  wire logic i_cmd_two,
  input  wire logic i_flip,
  input  wire logic i_select_on,
  input  wire logic i_select,
  input  wire logic i_rc_req,
  input  wire logic i_rx_req,
  output logic      o_control_input_one,
  output logic      o_control_input_two,
  output logic      o_flip_over_input,
  output logic      o_rc_pulse_seen,
  output logic      o_serial_rx_seen
);
  always_ff @(posedge i_clock)
  begin
    o_control_input_one <= i_cmd_one;
    // with slave select, input two selects: high runs
    o_control_input_two <= i_select_on ? i_select : i_cmd_two;
    o_flip_over_input   <= i_flip;
    o_rc_pulse_seen     <= i_rc_req;
    o_serial_rx_seen    <= i_rx_req;
  end
endmodule

// File: mcs_mode_status_bench.sv
/*
  Self-checking bench for mcs_mode_status.
  Assumes shortened blink timings.
*/
`timescale 1ns/1ps
module mcs_mode_status_bench;
  import mcs_pkg::*;
  logic i_clock, i_resetn, c_one, c_two, flip, sel_on, sel, rc_req, rx_req;
  logic oc, ot, mbh, lbl, qf, c1, c2, fl, rcp, rxp;
  logic [9:0] sw;
  logic [1:0] md, pa, pb;
  logic [15:0] mv;
  mcs_mode_t o_mode;
  logic o_command_one, o_command_two, o_command_enable, o_flip_over, o_serial_tx_enable, o_encoder_enable;
  logic o_motor_drive_enable, o_low_batt_fault, o_activity_indicator, o_motor_active_indicator, o_fault_indicator;
  logic [2:0] o_bus_address;
  logic [31:0] o_enc_count_one, o_enc_count_two;
  int n_fail, compares, cnt, thr;
  logic [2:0] msw [4] = '{3'b001, 3'b000, 3'b010, 3'b100};
  localparam int LAMP = 20, DARK = 5, FAST = 8, HALF = 10, FL_ON = 12, FL_OFF = 4;

  mcs_host_model host (.i_clock(i_clock), .i_cmd_one(c_one), .i_cmd_two(c_two), .i_flip(flip),
    .i_select_on(sel_on), .i_select(sel), .i_rc_req(rc_req), .i_rx_req(rx_req), .o_control_input_one(c1),
    .o_control_input_two(c2), .o_flip_over_input(fl), .o_rc_pulse_seen(rcp), .o_serial_rx_seen(rxp));

  mcs_mode_status #(.SELF_TEST_ON_CYC(LAMP), .SELF_TEST_OFF_CYC(LAMP), .ACTIVITY_DARK_CYC(DARK),
    .FAST_TOGGLE_CYC(FAST), .HALF_SEC_CYC(HALF), .FLICKER_ON_CYC(FL_ON), .FLICKER_OFF_CYC(FL_OFF)) dut (.i_clock,
    .i_resetn, .i_config_switch(sw), .i_control_input_one(c1), .i_control_input_two(c2), .i_flip_over_input(fl),
    .i_rc_pulse_seen(rcp), .i_serial_rx_seen(rxp), .i_motor_driven(md), .i_over_current(oc), .i_over_temp(ot),
    .i_main_batt_high(mbh), .i_logic_batt_low(lbl), .i_quad_fail(qf), .i_main_batt_mv(mv),
    .i_enc_phase_a(pa), .i_enc_phase_b(pb), .o_mode, .o_command_one, .o_command_two, .o_command_enable,
    .o_flip_over, .o_serial_tx_enable, .o_bus_address, .o_encoder_enable, .o_enc_count_one, .o_enc_count_two,
    .o_motor_drive_enable, .o_low_batt_fault, .o_activity_indicator, .o_motor_active_indicator, .o_fault_indicator);

  always #5 i_clock = ~i_clock;

  task automatic step(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic do_reset();
    i_resetn = 1'b0;
    step(3);
    i_resetn = 1'b1;
  endtask

  // skips the phase in progress so a restarted pattern is measured whole
  task automatic blink(input int on_c, input int off_c);
    int hi, lo;
    hi = 0;
    lo = 0;
    while (o_fault_indicator === 1'b1) step(1);
    while (o_fault_indicator !== 1'b1) step(1);
    while (o_fault_indicator === 1'b1)
    begin
      hi++;
      step(1);
    end
    while (o_fault_indicator !== 1'b1)
    begin
      lo++;
      step(1);
    end
    check(hi, on_c);
    check(lo, off_c);
  endtask

  task automatic quad(input int ch, input bit fwd);
    logic [1:0] seq [4];
    if (fwd) seq = '{2'b10, 2'b11, 2'b01, 2'b00};
    else seq = '{2'b01, 2'b11, 2'b10, 2'b00};
    for (int k = 0; k < 4; k++)
    begin
      pa[ch] = seq[k][1];
      pb[ch] = seq[k][0];
      step(2);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge i_clock);
    n_fail++;
    give_verdict();
  end

  initial
  begin
    {i_clock, c_one, c_two, flip, sel_on, sel, rc_req, rx_req, oc, ot, mbh, lbl, qf} = '0;
    {sw, md, pa, pb} = '0;
    mv = 16'h7fff;
    n_fail = 0;
    compares = 0;
    do_reset();
    cnt = 0;
    for (int k = 0; k < 130; k++)
    begin
      thr = o_activity_indicator & o_motor_active_indicator & o_fault_indicator;
      step(1);
      if ((o_activity_indicator & o_motor_active_indicator & o_fault_indicator) === 1'b1 && thr == 0) cnt++;
    end
    check(cnt, 3);
    check(o_activity_indicator, 1);
    flip = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      sw[2:0] = msw[i];
      md = 2'b10;
      step(3);
      check(o_mode, i);
      check(o_encoder_enable, i == 3);
      check(o_serial_tx_enable, i == 3);
      check(o_flip_over, i < 2);
      check(o_motor_active_indicator, 1);
      md = 2'b00;
      rc_req = (i < 2);
      rx_req = (i >= 2);
      step(1);
      {rc_req, rx_req} = 2'b00;
      cnt = 0;
      repeat (12)
      begin
        if (o_activity_indicator === 1'b0) cnt++;
        step(1);
      end
      check(cnt, (i == 1) ? 0 : DARK);
      check(o_motor_active_indicator, 0);
    end
    sw[2:0] = 3'b011;
    sel_on = 1'b1;
    step(3);
    check(o_command_enable, 0);
    sel = 1'b1;
    c_one = 1'b1;
    step(3);
    check(o_command_enable, 1);
    check(o_command_one, 1);
    sel_on = 1'b0;
    c_two = 1'b1;
    sw[2:0] = 3'b001;
    quad(0, 1);
    check(o_enc_count_one, 0);
    check(o_command_two, 1);
    sw[2:0] = 3'b100;
    for (int k = 0; k < 8; k++)
    begin
      sw[5:3] = k[2:0];
      step(2);
      check(o_bus_address, k);
    end
    quad(0, 1);
    {pa[0], pb[0]} = 2'b11;
    step(2);
    {pa[0], pb[0]} = 2'b00;
    step(2);
    check(o_enc_count_one, 4);
    quad(1, 0);
    check(o_enc_count_two, 32'hfffffffc);
    sw[2:0] = 3'b000;
    for (int c = 0; c < 8; c++)
    begin
      thr = (c < 2) ? 6000 : c * 3000;
      sw[9:7] = c[2:0];
      mv = 16'(thr - 1);
      step(3);
      check(o_low_batt_fault, c != 0);
      check(o_motor_drive_enable, c == 0);
      mv = 16'(thr);
      step(3);
      check(o_low_batt_fault, 0);
    end
    sw[9:7] = 3'h2;
    mv = 16'h0fa0;
    blink(HALF, HALF);
    mv = 16'h7fff;
    ot = 1'b1;
    blink(FAST, FAST);
    ot = 1'b0;
    mbh = 1'b1;
    blink(FL_ON, FL_OFF);
    mbh = 1'b0;
    lbl = 1'b1;
    blink(HALF, HALF);
    lbl = 1'b0;
    oc = 1'b1;
    step(3);
    cnt = 0;
    repeat (20)
    begin
      if (o_fault_indicator === 1'b1) cnt++;
      step(1);
    end
    check(cnt, 20);
    oc = 1'b0;
    // quad fail latches until reset
    qf = 1'b1;
    sw[2:0] = 3'b100;
    do_reset();
    step(130);
    blink(HALF, HALF);
    check(o_motor_active_indicator, !o_fault_indicator);
    give_verdict();
  end
endmodule
